// *** include/ubra_pkg.sv ***
// constants shared by both ends of the banked register link
package ubra_pkg;
  // register offsets on the link
  localparam logic [2:0] OFF_DIV_LOW = 3'h0;
  localparam logic [2:0] OFF_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFF_ENH_CTRL = 3'h2;
  localparam logic [2:0] OFF_LINE_CTRL = 3'h3;
  localparam logic [2:0] OFF_MODEM_CTRL = 3'h4;
  localparam logic [2:0] OFF_RESUME_FIRST = 3'h4;
  localparam logic [2:0] OFF_RESUME_SECOND = 3'h5;
  localparam logic [2:0] OFF_STOP_FIRST = 3'h6;
  localparam logic [2:0] OFF_THRESHOLD = 3'h6;
  localparam logic [2:0] OFF_STOP_SECOND = 3'h7;
  localparam logic [2:0] OFF_TRIGGER = 3'h7;
  localparam logic [2:0] OFF_FIFO_READY = 3'h7;
  // bank select values of line_control
  localparam logic [7:0] LC_DIVISOR_BANK = 8'h80;
  localparam logic [7:0] LC_ENHANCED_BANK = 8'hBF;
  localparam logic [7:0] LC_NORMAL_BANK = 8'h00;
  // field positions
  localparam int LC_DIV_ACCESS_BIT = 7;
  localparam int ENH_ENABLE_BIT = 4;
  localparam int MC_HIDDEN_BIT = 6;
  localparam int MC_LOOPBACK_BIT = 4;
  localparam int MC_PRESCALE_BIT = 7;
  // masks used by the host sequences and by the device write protection
  localparam logic [7:0] ENH_ENABLE_MASK = 8'h10;
  localparam logic [7:0] MC_HIDDEN_MASK = 8'h40;
  localparam logic [7:0] MC_READY_KEEP_MASK = 8'hEF;
  localparam logic [7:0] MC_PRESCALE_CLR_MASK = 8'h7F;
  localparam logic [7:0] MC_PRESCALE_SET_MASK = 8'h80;
  localparam logic [7:0] MC_PROTECTED_MASK = 8'hE0;
  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // prescaler divide ratios
  localparam logic [1:0] PRESCALE_DIV4_LAST = 2'h3;
  // host software port: offsets of its own registers
  localparam logic [2:0] HOFF_COMMAND = 3'h0;
  localparam logic [2:0] HOFF_VALUE1 = 3'h1;
  localparam logic [2:0] HOFF_VALUE2 = 3'h2;
  localparam logic [2:0] HOFF_STATUS = 3'h3;
  localparam logic [2:0] HOFF_RESULT = 3'h4;
  // host commands
  localparam logic [3:0] CMD_BAUD = 4'h1;
  localparam logic [3:0] CMD_CHARS_FIRST = 4'h2;
  localparam logic [3:0] CMD_CHARS_SECOND = 4'h3;
  localparam logic [3:0] CMD_FLOW_MODE = 4'h4;
  localparam logic [3:0] CMD_THRESHOLD = 4'h5;
  localparam logic [3:0] CMD_TRIGGER = 4'h6;
  localparam logic [3:0] CMD_READ_READY = 4'h7;
  localparam logic [3:0] CMD_PRESCALE1 = 4'h8;
  localparam logic [3:0] CMD_PRESCALE4 = 4'h9;
  // data sources of a host step
  localparam logic [3:0] SRC_CONST = 4'h0;
  localparam logic [3:0] SRC_VALUE1 = 4'h1;
  localparam logic [3:0] SRC_VALUE2 = 4'h2;
  localparam logic [3:0] SRC_TEMP1 = 4'h3;
  localparam logic [3:0] SRC_TEMP2 = 4'h4;
  localparam logic [3:0] SRC_TEMP3 = 4'h5;
  localparam logic [3:0] SRC_T2_ENH = 4'h6;
  localparam logic [3:0] SRC_T3_HIDDEN = 4'h7;
  localparam logic [3:0] SRC_T3_PRE_CLR = 4'h8;
  localparam logic [3:0] SRC_T3_PRE_SET = 4'h9;
  localparam logic [3:0] SRC_T1_READY = 4'hA;
  // read destinations
  localparam logic [1:0] DST_TEMP1 = 2'h0;
  localparam logic [1:0] DST_TEMP2 = 2'h1;
  localparam logic [1:0] DST_TEMP3 = 2'h2;
  localparam logic [1:0] DST_RESULT = 2'h3;

  // one step of a host sequence
  typedef struct packed {
    logic last;
    logic is_read;
    logic [2:0] addr;
    logic [3:0] src;
    logic [7:0] konst;
    logic [1:0] dst;
  } ubra_step_t;

  // host sequencer states
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_RUN = 4'b0010,
    HS_RD_STROBE = 4'b0100,
    HS_RD_DATA = 4'b1000
  } ubra_hstate_t;
endpackage

// *** include/ubra_if.sv ***
// parallel register link between host and device
`timescale 1ns/100ps
interface ubra_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// *** verilog/ubra_device.sv ***
// banked register map of one serial channel: decode, storage, derived levels
`timescale 1ns/100ps
module ubra_device
  import ubra_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register link
  ubra_if.device link,
  // channel status in
  input wire logic [3:0] fifo_ready_in,
  input wire logic [5:0] fcr_tx_trigger,
  input wire logic [5:0] fcr_rx_trigger,
  // configuration out
  output logic [7:0] line_control,
  output logic [7:0] modem_control,
  output logic [7:0] enhanced_feature_control,
  output logic [15:0] divisor,
  output logic [3:0] sw_flow_mode,
  output logic [7:0] resume_char_first,
  output logic [7:0] resume_char_second,
  output logic [7:0] stop_char_first,
  output logic [7:0] stop_char_second,
  output logic [5:0] halt_level,
  output logic [5:0] resume_level,
  output logic [5:0] tx_trigger_level,
  output logic [5:0] rx_trigger_level,
  output logic prescale_tick
);
  logic [7:0] line_control_r;
  logic [7:0] modem_control_r;
  logic [7:0] enh_r;
  logic [7:0] div_low_r;
  logic [7:0] div_high_r;
  logic [7:0] resume1_r;
  logic [7:0] resume2_r;
  logic [7:0] stop1_r;
  logic [7:0] stop2_r;
  logic [7:0] threshold_r;
  logic [7:0] trigger_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] pre_cnt_r;
  logic prescale_tick_r;
  logic div_bank;
  logic enh_bank;
  logic norm_bank;
  logic enh_on;
  logic hidden_on;
  logic ready_on;

  // bank decode from line_control and the hidden-bank bits
  assign div_bank = line_control_r[LC_DIV_ACCESS_BIT];
  assign enh_bank = (line_control_r == LC_ENHANCED_BANK);
  assign norm_bank = ~line_control_r[LC_DIV_ACCESS_BIT];
  assign enh_on = enh_r[ENH_ENABLE_BIT];
  assign hidden_on = norm_bank & enh_on & modem_control_r[MC_HIDDEN_BIT];
  assign ready_on = norm_bank & modem_control_r[MC_HIDDEN_BIT] & ~modem_control_r[MC_LOOPBACK_BIT];

  // line_control answers at its offset in every bank
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      line_control_r <= REG_RESET;
    end else if (link.wr && link.addr == OFF_LINE_CTRL) begin
      line_control_r <= link.wdata;
    end
  end

  // divisor latches, reached while the access bit is set
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      div_low_r <= REG_RESET;
      div_high_r <= REG_RESET;
    end else if (link.wr && div_bank) begin
      if (link.addr == OFF_DIV_LOW) begin
        div_low_r <= link.wdata;
      end
      if (link.addr == OFF_DIV_HIGH) begin
        div_high_r <= link.wdata;
      end
    end
  end

  // enhanced bank: feature register and flow characters
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enh_r <= REG_RESET;
      resume1_r <= REG_RESET;
      resume2_r <= REG_RESET;
      stop1_r <= REG_RESET;
      stop2_r <= REG_RESET;
    end else if (link.wr && enh_bank) begin
      unique case (link.addr)
        OFF_ENH_CTRL: enh_r <= link.wdata;
        OFF_RESUME_FIRST: resume1_r <= link.wdata;
        OFF_RESUME_SECOND: resume2_r <= link.wdata;
        OFF_STOP_FIRST: stop1_r <= link.wdata;
        OFF_STOP_SECOND: stop2_r <= link.wdata;
        default: ;
      endcase
    end
  end

  // modem control; the top three bits are write-protected until enhanced is on
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      modem_control_r <= REG_RESET;
    end else if (link.wr && norm_bank && link.addr == OFF_MODEM_CTRL) begin
      if (enh_on) begin
        modem_control_r <= link.wdata;
      end else begin
        modem_control_r <= (modem_control_r & MC_PROTECTED_MASK) | (link.wdata & ~MC_PROTECTED_MASK);
      end
    end
  end

  // hidden threshold and trigger registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      threshold_r <= REG_RESET;
      trigger_r <= REG_RESET;
    end else if (link.wr && hidden_on) begin
      if (link.addr == OFF_THRESHOLD) begin
        threshold_r <= link.wdata;
      end
      if (link.addr == OFF_TRIGGER) begin
        trigger_r <= link.wdata;
      end
    end
  end

  // read mux; data stands only in the cycle after the strobe
  always_comb begin
    rdata_nxt = REG_RESET;
    if (link.rd) begin
      if (link.addr == OFF_LINE_CTRL) begin
        rdata_nxt = line_control_r;
      end else if (div_bank && link.addr == OFF_DIV_LOW) begin
        rdata_nxt = div_low_r;
      end else if (div_bank && link.addr == OFF_DIV_HIGH) begin
        rdata_nxt = div_high_r;
      end else if (enh_bank) begin
        unique case (link.addr)
          OFF_ENH_CTRL: rdata_nxt = enh_r;
          OFF_RESUME_FIRST: rdata_nxt = resume1_r;
          OFF_RESUME_SECOND: rdata_nxt = resume2_r;
          OFF_STOP_FIRST: rdata_nxt = stop1_r;
          OFF_STOP_SECOND: rdata_nxt = stop2_r;
          default: rdata_nxt = REG_RESET;
        endcase
      end else if (norm_bank && link.addr == OFF_MODEM_CTRL) begin
        rdata_nxt = modem_control_r;
      end else if (hidden_on && link.addr == OFF_THRESHOLD) begin
        rdata_nxt = threshold_r;
      end else if (ready_on && link.addr == OFF_FIFO_READY) begin
        // ready status wins reads at offset 7; the trigger register stays writable there
        // unused ready bits always read as zero
        rdata_nxt = {2'h0, fifo_ready_in[3:2], 2'h0, fifo_ready_in[1:0]};
      end else if (hidden_on && link.addr == OFF_TRIGGER) begin
        rdata_nxt = trigger_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_r <= REG_RESET;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // prescaler: one tick per clock, or one per four clocks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre_cnt_r <= 2'h0;
      prescale_tick_r <= 1'b0;
    end else if (modem_control_r[MC_PRESCALE_BIT]) begin
      pre_cnt_r <= pre_cnt_r + 2'h1;
      prescale_tick_r <= (pre_cnt_r == PRESCALE_DIV4_LAST);
    end else begin
      pre_cnt_r <= 2'h0;
      prescale_tick_r <= 1'b1;
    end
  end

  // derived flow and trigger levels, in bytes
  assign halt_level = {threshold_r[3:0], 2'h0};
  assign resume_level = {threshold_r[7:4], 2'h0};
  assign tx_trigger_level = (trigger_r[3:0] == 4'h0) ? fcr_tx_trigger : {trigger_r[3:0], 2'h0};
  assign rx_trigger_level = (trigger_r[7:4] == 4'h0) ? fcr_rx_trigger : {trigger_r[7:4], 2'h0};

  assign link.rdata = rdata_r;
  assign line_control = line_control_r;
  assign modem_control = modem_control_r;
  assign enhanced_feature_control = enh_r;
  assign divisor = {div_high_r, div_low_r};
  assign sw_flow_mode = enh_r[3:0];
  assign resume_char_first = resume1_r;
  assign resume_char_second = resume2_r;
  assign stop_char_first = stop1_r;
  assign stop_char_second = stop2_r;
  assign prescale_tick = prescale_tick_r;
endmodule // ubra_device

// *** verilog/ubra_host.sv ***
// host sequencer that walks the banked access recipes on the register link
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module ubra_host
  import ubra_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // software port
  input wire logic [2:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // register link
  ubra_if.host link
);
  ubra_hstate_t state_r;
  logic [3:0] cmd_r;
  logic [3:0] step_r;
  logic [7:0] value1_r;
  logic [7:0] value2_r;
  logic [7:0] temp1_r;
  logic [7:0] temp2_r;
  logic [7:0] temp3_r;
  logic [7:0] result_r;
  logic [7:0] sw_rdata_r;
  logic [2:0] addr_r;
  logic [7:0] wdata_r;
  logic wr_r;
  logic rd_r;
  ubra_step_t st;
  logic [7:0] src_val;

  // one step of the selected recipe
  function automatic ubra_step_t step_of(input logic [3:0] cmd, input logic [3:0] idx);
    ubra_step_t s;
    s = '{last: 1'b0, is_read: 1'b0, addr: OFF_LINE_CTRL, src: SRC_CONST, konst: 8'h00, dst: DST_TEMP1};
    if (cmd == CMD_READ_READY) begin
      unique case (idx)
        4'h0: s = '{1'b0, 1'b1, OFF_MODEM_CTRL, SRC_CONST, 8'h00, DST_TEMP1};
        4'h1: s = '{1'b0, 1'b0, OFF_MODEM_CTRL, SRC_T1_READY, 8'h00, DST_TEMP1};
        4'h2: s = '{1'b0, 1'b1, OFF_FIFO_READY, SRC_CONST, 8'h00, DST_RESULT};
        default: s = '{1'b1, 1'b0, OFF_MODEM_CTRL, SRC_TEMP1, 8'h00, DST_TEMP1};
      endcase
    end else if (cmd == CMD_BAUD || cmd == CMD_CHARS_FIRST || cmd == CMD_CHARS_SECOND || cmd == CMD_FLOW_MODE) begin
      unique case (idx)
        4'h0: s = '{1'b0, 1'b1, OFF_LINE_CTRL, SRC_CONST, 8'h00, DST_TEMP1};
        4'h1: s.konst = (cmd == CMD_BAUD) ? LC_DIVISOR_BANK : LC_ENHANCED_BANK;
        4'h2: begin
          s.addr = (cmd == CMD_BAUD) ? OFF_DIV_LOW : (cmd == CMD_CHARS_FIRST) ? OFF_STOP_FIRST :
                   (cmd == CMD_CHARS_SECOND) ? OFF_STOP_SECOND : OFF_ENH_CTRL;
          s.src = SRC_VALUE1;
        end
        4'h3: begin
          if (cmd == CMD_FLOW_MODE) begin
            s.src = SRC_TEMP1;
            s.last = 1'b1;
          end else begin
            s.addr = (cmd == CMD_BAUD) ? OFF_DIV_HIGH : (cmd == CMD_CHARS_FIRST) ? OFF_RESUME_FIRST : OFF_RESUME_SECOND;
            s.src = SRC_VALUE2;
          end
        end
        default: s = '{1'b1, 1'b0, OFF_LINE_CTRL, SRC_TEMP1, 8'h00, DST_TEMP1};
      endcase
    end else begin
      // hidden-bank recipes share an opening and a closing
      unique case (idx)
        4'h0: s = '{1'b0, 1'b1, OFF_LINE_CTRL, SRC_CONST, 8'h00, DST_TEMP1};
        4'h1: s.konst = LC_ENHANCED_BANK;
        4'h2: s = '{1'b0, 1'b1, OFF_ENH_CTRL, SRC_CONST, 8'h00, DST_TEMP2};
        4'h3: s = '{1'b0, 1'b0, OFF_ENH_CTRL, SRC_T2_ENH, 8'h00, DST_TEMP1};
        4'h4: s.konst = LC_NORMAL_BANK;
        4'h5: s = '{1'b0, 1'b1, OFF_MODEM_CTRL, SRC_CONST, 8'h00, DST_TEMP3};
        4'h6: begin
          s.addr = OFF_MODEM_CTRL;
          s.src = (cmd == CMD_PRESCALE1) ? SRC_T3_PRE_CLR : (cmd == CMD_PRESCALE4) ? SRC_T3_PRE_SET : SRC_T3_HIDDEN;
        end
        4'h7, 4'h8: begin
          if (cmd == CMD_PRESCALE1 || cmd == CMD_PRESCALE4) begin
            // prescale keeps its new modem value: repeat the write instead of restoring
            s.addr = OFF_MODEM_CTRL;
            s.src = (cmd == CMD_PRESCALE1) ? SRC_T3_PRE_CLR : SRC_T3_PRE_SET;
          end else if (idx == 4'h7) begin
            s.addr = (cmd == CMD_THRESHOLD) ? OFF_THRESHOLD : OFF_TRIGGER;
            s.src = SRC_VALUE1;
          end else begin
            s.addr = OFF_MODEM_CTRL;
            s.src = SRC_TEMP3;
          end
        end
        4'h9: s.konst = LC_ENHANCED_BANK;
        4'hA: begin
          s.addr = OFF_ENH_CTRL;
          s.src = SRC_TEMP2;
        end
        default: s = '{1'b1, 1'b0, OFF_LINE_CTRL, SRC_TEMP1, 8'h00, DST_TEMP1};
      endcase
    end
    return s;
  endfunction

  assign st = step_of(cmd_r, step_r);

  // set masks are merged by OR and clear masks by AND so saved bits survive
  always_comb begin
    unique case (st.src)
      SRC_VALUE1: src_val = value1_r;
      SRC_VALUE2: src_val = value2_r;
      SRC_TEMP1: src_val = temp1_r;
      SRC_TEMP2: src_val = temp2_r;
      SRC_TEMP3: src_val = temp3_r;
      SRC_T2_ENH: src_val = temp2_r | ENH_ENABLE_MASK;
      SRC_T3_HIDDEN: src_val = temp3_r | MC_HIDDEN_MASK;
      SRC_T3_PRE_CLR: src_val = temp3_r & MC_PRESCALE_CLR_MASK;
      SRC_T3_PRE_SET: src_val = temp3_r | MC_PRESCALE_SET_MASK;
      SRC_T1_READY: src_val = (temp1_r & MC_READY_KEEP_MASK) | MC_HIDDEN_MASK;
      default: src_val = st.konst;
    endcase
  end

  // recipe walker; a read waits two cycles for its data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= HS_IDLE;
      step_r <= 4'h0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= 3'h0;
      wdata_r <= 8'h00;
    end else begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      unique case (state_r)
        HS_IDLE: begin
          if (sw_wr && sw_addr == HOFF_COMMAND && sw_wdata[3:0] >= CMD_BAUD && sw_wdata[3:0] <= CMD_PRESCALE4) begin
            state_r <= HS_RUN;
            step_r <= 4'h0;
          end
        end
        HS_RUN: begin
          addr_r <= st.addr;
          wdata_r <= st.is_read ? 8'h00 : src_val;
          wr_r <= ~st.is_read;
          rd_r <= st.is_read;
          if (st.is_read) begin
            state_r <= HS_RD_STROBE;
          end else if (st.last) begin
            state_r <= HS_IDLE;
          end else begin
            step_r <= step_r + 4'h1;
          end
        end
        HS_RD_STROBE: state_r <= HS_RD_DATA;
        HS_RD_DATA: begin
          state_r <= st.last ? HS_IDLE : HS_RUN;
          step_r <= step_r + 4'h1;
        end
        default: state_r <= HS_IDLE;
      endcase
    end
  end

  // read results land in the saved temporaries or in the result register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      temp1_r <= 8'h00;
      temp2_r <= 8'h00;
      temp3_r <= 8'h00;
      result_r <= 8'h00;
    end else if (state_r == HS_RD_DATA) begin
      unique case (st.dst)
        DST_TEMP1: temp1_r <= link.rdata;
        DST_TEMP2: temp2_r <= link.rdata;
        DST_TEMP3: temp3_r <= link.rdata;
        DST_RESULT: result_r <= link.rdata;
      endcase
    end
  end

  // software registers; command and values are ignored while busy
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_r <= 4'h0;
      value1_r <= 8'h00;
      value2_r <= 8'h00;
      sw_rdata_r <= 8'h00;
    end else begin
      if (sw_wr && state_r == HS_IDLE) begin
        unique case (sw_addr)
          HOFF_COMMAND: cmd_r <= sw_wdata[3:0];
          HOFF_VALUE1: value1_r <= sw_wdata;
          HOFF_VALUE2: value2_r <= sw_wdata;
          default: ;
        endcase
      end
      sw_rdata_r <= 8'h00;
      if (sw_rd) begin
        unique case (sw_addr)
          HOFF_COMMAND: sw_rdata_r <= {4'h0, cmd_r};
          HOFF_VALUE1: sw_rdata_r <= value1_r;
          HOFF_VALUE2: sw_rdata_r <= value2_r;
          HOFF_STATUS: sw_rdata_r <= {7'h00, state_r != HS_IDLE};
          HOFF_RESULT: sw_rdata_r <= result_r;
          default: sw_rdata_r <= 8'h00;
        endcase
      end
    end
  end

  assign sw_rdata = sw_rdata_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;
  assign link.wr = wr_r;
  assign link.rd = rd_r;
endmodule // ubra_host

// *** sim/ubra_link_sva.sv ***
// link checker for the banked register host and device pair
`timescale 1ns/100ps
module ubra_link_sva
  import ubra_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // link signals
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  logic [7:0] lc_r;
  logic lc_rd;
  logic mc_rd;
  logic enh_rd;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // reads of the registers the host must save
  assign lc_rd = rd && addr == OFF_LINE_CTRL;
  assign mc_rd = rd && addr == OFF_MODEM_CTRL;
  assign enh_rd = rd && addr == OFF_ENH_CTRL;

  // shadow of line_control; offset 3 reaches it in every bank
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lc_r <= REG_RESET;
    end else if (wr && addr == OFF_LINE_CTRL) begin
      lc_r <= wdata;
    end
  end

  a_rdata_idle_zero: // read data only in the answer cycle
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("read data outside answer cycle");
  a_strobe_never_both:
    assert property (!(wr && rd)) else $error("write and read strobes together");
  a_line_ctrl_readback:
    assert property (lc_rd |=> rdata == lc_r) else $error("line control read back wrong");
  a_lc_saved_first:
    assert property (wr && addr == OFF_LINE_CTRL && wdata == LC_DIVISOR_BANK |-> $past(lc_rd, 3))
      else $error("divisor bank opened without saving line control");
  a_divisor_byte_pair:
    assert property (wr && addr == OFF_DIV_LOW && lc_r == LC_DIVISOR_BANK |=> wr && addr == OFF_DIV_HIGH)
      else $error("divisor high byte not written after low byte");
  a_enh_then_lc:
    assert property (wr && addr == OFF_ENH_CTRL && lc_r == LC_ENHANCED_BANK |=> wr && addr == OFF_LINE_CTRL)
      else $error("line control not written after enhanced register");
  a_enh_or_keep:
    assert property (wr && addr == OFF_ENH_CTRL && $past(enh_rd, 3)
      |-> wdata == ($past(rdata, 2) | ENH_ENABLE_MASK)) else $error("enhanced enable not merged by OR");
  a_modem_keep_bits:
    assert property (wr && addr == OFF_MODEM_CTRL && $past(mc_rd, 3)
      |-> (wdata & 8'h2F) == ($past(rdata, 2) & 8'h2F)) else $error("saved modem bits altered");
  a_ready_needs_hidden:
    assert property (rd && addr == OFF_FIFO_READY |-> $past(wr) && $past(addr) == OFF_MODEM_CTRL
      && ($past(wdata) & 8'h50) == MC_HIDDEN_MASK) else $error("ready read without hidden modem setting");
  a_ready_then_restore:
    // the saved modem value was answered six cycles before the restore write
    assert property (rd && addr == OFF_FIFO_READY |-> ##3 wr && addr == OFF_MODEM_CTRL && wdata == $past(rdata, 6))
      else $error("modem control not restored after ready read");
endmodule // ubra_link_sva

// *** sim/uart_banked_register_access_test.sv ***
// testbench joining host sequencer and banked register device
`timescale 1ns/100ps
module uart_banked_register_access_test;
  import ubra_pkg::*;
  typedef struct packed {
    logic [3:0] cmd;
    logic [7:0] v1;
    logic [7:0] v2;
    logic [15:0] exp;
    logic [3:0] ticks;
  } ubra_row_t;
  logic sys_clk, srst, sw_wr, sw_rd, prescale_tick;
  logic [2:0] sw_addr;
  logic [7:0] sw_wdata, sw_rdata, line_control, modem_control, enhanced_feature_control, res;
  logic [7:0] resume_char_first, resume_char_second, stop_char_first, stop_char_second;
  logic [15:0] divisor;
  logic [3:0] fifo_ready_in, sw_flow_mode, tk;
  logic [5:0] fcr_tx_trigger, fcr_rx_trigger, halt_level, resume_level, tx_trigger_level, rx_trigger_level;
  int n_fail, compares;
  // one command per row with the outputs it should leave behind
  ubra_row_t rows [11] = '{
    '{CMD_BAUD, 8'h34, 8'h12, 16'h1234, 4'h8}, '{CMD_CHARS_FIRST, 8'h13, 8'h11, 16'h1113, 4'h8},
    '{CMD_CHARS_SECOND, 8'h93, 8'h91, 16'h9193, 4'h8}, '{CMD_FLOW_MODE, 8'h1A, 8'h00, 16'h0A1A, 4'h8},
    '{CMD_THRESHOLD, 8'hF3, 8'h00, 16'h0F0C, 4'h8}, '{CMD_THRESHOLD, 8'h0F, 8'h00, 16'h003C, 4'h8},
    '{CMD_TRIGGER, 8'h00, 8'h00, 16'h0408, 4'h8}, '{CMD_TRIGGER, 8'h50, 8'h00, 16'h0508, 4'h8},
    '{CMD_READ_READY, 8'h00, 8'h00, 16'h0033, 4'h8}, '{CMD_PRESCALE4, 8'h00, 8'h00, 16'h0080, 4'h2},
    '{CMD_PRESCALE1, 8'h00, 8'h00, 16'h0000, 4'h8}};

  ubra_if i_ubra_if ();
  ubra_host i_ubra_host (.sys_clk(sys_clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(i_ubra_if));
  ubra_device i_ubra_device (.sys_clk(sys_clk), .srst(srst), .link(i_ubra_if), .fifo_ready_in(fifo_ready_in),
    .fcr_tx_trigger(fcr_tx_trigger), .fcr_rx_trigger(fcr_rx_trigger), .line_control(line_control),
    .modem_control(modem_control), .enhanced_feature_control(enhanced_feature_control), .divisor(divisor),
    .sw_flow_mode(sw_flow_mode), .resume_char_first(resume_char_first), .resume_char_second(resume_char_second),
    .stop_char_first(stop_char_first), .stop_char_second(stop_char_second), .halt_level(halt_level),
    .resume_level(resume_level), .tx_trigger_level(tx_trigger_level), .rx_trigger_level(rx_trigger_level),
    .prescale_tick(prescale_tick));
  ubra_link_sva i_ubra_link_sva (.sys_clk(sys_clk), .srst(srst), .addr(i_ubra_if.addr), .wdata(i_ubra_if.wdata),
    .wr(i_ubra_if.wr), .rd(i_ubra_if.rd), .rdata(i_ubra_if.rdata));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // pick the outputs that a command should have changed
  function automatic logic [15:0] got(input logic [3:0] c, input logic [7:0] r);
    case (c)
      CMD_BAUD: got = divisor;
      CMD_CHARS_FIRST: got = {resume_char_first, stop_char_first};
      CMD_CHARS_SECOND: got = {resume_char_second, stop_char_second};
      CMD_FLOW_MODE: got = {4'h0, sw_flow_mode, enhanced_feature_control};
      CMD_THRESHOLD: got = {4'h0, resume_level, halt_level};
      CMD_TRIGGER: got = {4'h0, rx_trigger_level, tx_trigger_level};
      CMD_READ_READY: got = {modem_control, r};
      default: got = {8'h00, modem_control};
    endcase
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // software port cycles; entered and left at a rising edge
  task automatic bw(input logic [2:0] a, input logic [7:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic br(input logic [2:0] a, output logic [7:0] d);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
    @(posedge sys_clk);
  endtask

  task automatic start(input logic [3:0] c, input logic [7:0] v1, input logic [7:0] v2);
    bw(HOFF_VALUE1, v1);
    bw(HOFF_VALUE2, v2);
    bw(HOFF_COMMAND, {4'h0, c});
  endtask

  // poll busy under a bound so a stuck sequencer cannot hang the run
  task automatic wait_idle();
    logic [7:0] s;
    int k;
    k = 0;
    do begin
      br(HOFF_STATUS, s);
      k++;
    end while (s[0] !== 1'b0 && k < 200);
    if (k >= 200) begin
      n_fail++;
      $display("[FAIL] %0t sequencer stays busy", $time);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of some four hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end

  // main sequence
  initial begin
    srst = 1'b1;
    sw_addr = 3'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    fifo_ready_in = 4'hF;
    fcr_tx_trigger = 6'h08;
    fcr_rx_trigger = 6'h10;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({line_control, modem_control}, 16'h0000);
    chk(divisor, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 11; i++) begin
      start(rows[i].cmd, rows[i].v1, rows[i].v2);
      wait_idle();
      res = 8'h00;
      if (rows[i].cmd == CMD_READ_READY) br(HOFF_RESULT, res);
      chk(got(rows[i].cmd, res), rows[i].exp);
      chk({8'h00, line_control}, 16'h0000);
      tk = 4'h0;
      repeat (8) begin
        #1;
        tk = tk + {3'h0, prescale_tick};
        @(posedge sys_clk);
      end
      chk({12'h000, tk}, {12'h000, rows[i].ticks});
      $display("row %0d done", i);
    end
    // value write during a running sequence is ignored
    start(CMD_BAUD, 8'hFF, 8'hFF);
    bw(HOFF_VALUE1, 8'h00);
    wait_idle();
    chk(divisor, 16'hFFFF);
    $display("busy refusal done");
    // reset in the middle of a bank sequence
    start(CMD_CHARS_FIRST, 8'hAA, 8'hBB);
    repeat (6) @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({line_control, modem_control}, 16'h0000);
    chk({resume_char_first, stop_char_first}, 16'h0000);
    start(CMD_BAUD, 8'h01, 8'h00);
    wait_idle();
    chk(divisor, 16'h0001);
    $display("mid-sequence reset done");
    results();
  end
endmodule // uart_banked_register_access_test
